// file: src/dvcd_pkg.sv
// Constants shared by the data-value-compare debug logic.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package dvcd_pkg;

    // -----------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------
    localparam logic [4:0] OFS_DEBUG_CONTROL_1  = 5'h00;
    localparam logic [4:0] OFS_DEBUG_STATUS     = 5'h04;
    localparam logic [4:0] OFS_ADDR_COMPARE_1   = 5'h08;
    localparam logic [4:0] OFS_ADDR_COMPARE_2   = 5'h0C;
    localparam logic [4:0] OFS_DATA_VALUE_CMP_1 = 5'h10;
    localparam logic [4:0] OFS_DATA_VALUE_CMP_2 = 5'h14;
    localparam logic [4:0] OFS_SAVE_RESTORE_2   = 5'h18;

    // -----------------------------------------------------------------
    // debug_control_1 field positions (LSB of each field)
    // -----------------------------------------------------------------
    localparam int POS_RD_CHECK_1   = 0;
    localparam int POS_WR_CHECK_1   = 1;
    localparam int POS_RD_CHECK_2   = 2;
    localparam int POS_WR_CHECK_2   = 3;
    localparam int POS_RANGE_PAIR   = 4;
    localparam int POS_RANGE_EXCL   = 5;
    localparam int POS_MATCH_SIZE_1 = 6;
    localparam int POS_MATCH_SIZE_2 = 8;
    localparam int POS_VALUE_BE_1   = 10;
    localparam int POS_VALUE_BE_2   = 14;
    localparam int POS_VALUE_MODE_1 = 18;
    localparam int POS_VALUE_MODE_2 = 20;
    localparam int CONTROL_BITS     = 22;

    // debug_status bit positions
    localparam int POS_READ_HIT_1   = 0;
    localparam int POS_WRITE_HIT_1  = 1;
    localparam int POS_READ_HIT_2   = 2;
    localparam int POS_WRITE_HIT_2  = 3;

    // Reset values
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
    localparam logic [3:0]  RST_STATUS  = 4'h0;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    // Size field codes: byte, halfword, word, cacheline granularity
    localparam logic [1:0] SIZE_BYTE = 2'b00;
    localparam logic [1:0] SIZE_HALF = 2'b01;
    localparam logic [1:0] SIZE_WORD = 2'b10;
    localparam logic [1:0] SIZE_LINE = 2'b11;

    // Value compare modes
    localparam logic [1:0] MODE_UNDEF  = 2'b00;
    localparam logic [1:0] MODE_AND    = 2'b01;
    localparam logic [1:0] MODE_OR     = 2'b10;
    localparam logic [1:0] MODE_AND_OR = 2'b11;

    // Access kinds reported by the load/store pipeline
    typedef enum logic [3:0] {
        OP_LOAD            = 4'b0000,
        OP_STORE           = 4'b0001,
        OP_DBLK_INVALIDATE = 4'b0010,
        OP_DBLK_ZERO       = 4'b0011,
        OP_IBLK_INVALIDATE = 4'b0100,
        OP_DCLASS_INVAL    = 4'b0101,
        OP_ICLASS_INVAL    = 4'b0110,
        OP_DCACHE_READ     = 4'b0111,
        OP_ICACHE_READ     = 4'b1000,
        OP_DBLK_FLUSH      = 4'b1001,
        OP_DBLK_STORE      = 4'b1010,
        OP_DTOUCH          = 4'b1011,
        OP_DTOUCH_STORE    = 4'b1100,
        OP_ITOUCH          = 4'b1101,
        OP_DBLK_ALLOCATE   = 4'b1110
    } dvcd_op_e;

endpackage

// file: src/dvcd_value_unit.sv
// One value-compare channel: byte-enabled compare of an operand against
// a reference word in AND, OR or AND-OR mode. Purely combinational.
// Assumes big-endian byte numbering: byte 0 is bits 31:24.
`timescale 1ns/10ps

module dvcd_value_unit (
    input  wire logic [3:0]  byte_enable_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [31:0] reference_i,
    input  wire logic [31:0] operand_i,
    output logic             match_o
);

    logic [3:0] byte_eq;
    logic [3:0] hit;

    // Enable bit 3 pairs with byte 0, the most significant: the field is written MSB first
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            byte_eq[k] = (reference_i[8*k +: 8] == operand_i[8*k +: 8]);
        end
    end

    assign hit = byte_enable_i & byte_eq; // Disabled bytes never count

    // Mode 00 is left undefined; it never matches so a stray setting stays quiet
    always_comb begin
        unique case (mode_i)
            dvcd_pkg::MODE_AND:    match_o = (byte_enable_i != 4'h0) &&
                                             (hit == byte_enable_i);
            dvcd_pkg::MODE_OR:     match_o = (hit != 4'h0);
            dvcd_pkg::MODE_AND_OR: match_o = (hit[3] && hit[2]) ||
                                             (hit[1] && hit[0]);
            dvcd_pkg::MODE_UNDEF:  match_o = 1'b0;
        endcase
    end

endmodule

// file: src/dvcd_top.sv
// Data-value-compare debug events: classifies accesses, compares addresses
// and values, records hits and captures the follow-on instruction address.
// Assumes one completed access per acc_valid_i pulse from the pipeline and
// software on a classic Wishbone slave port, same clock.
//
// Summary of operation
// - Data block invalidate and block zero count as stores only.
// - Instruction block invalidate counts as a load only.
// - Congruence-class invalidates and cache reads raise no address events.
// - Data block flush and block store count as stores for debug.
// - Data touch, touch-for-store and instruction touch count as loads.
// - Data block allocate counts as a store only.
// - Value event needs address match first, then value match.
// - An enabled value channel suppresses plain address events on it.
// - Event taken after access; save_restore_2 gets next instruction address.
// - Value channel enabled exactly when its byte-enable field is non-zero.
// - Byte-enable bit k includes value byte 3-k (bits 8k+7:8k) in the compare.
// - Each channel has a two-bit mode; mode 00 is undefined.
// - Mode 01: every enabled byte must equal the operand byte.
// - Mode 10: at least one enabled byte must equal.
// - Mode 11: bytes 0,1 both equal or bytes 2,3 both equal.
// - First half of a split access records its event; second access lost only if debug_int_enable_i is set.
// - Read and write hits are recorded in separate status bits.
// - Address match with failed value compare sets no status bit.
// - Range pair makes the two addresses a range; size fields unused.
// - Size field masks none, bit 31, bits 30:31 or bits 27:31.
`timescale 1ns/10ps

module dvcd_top #(
    parameter int ADDR_W = 5
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Pipeline side
    input  wire logic              acc_valid_i,
    input  wire logic [3:0]        acc_op_i,
    input  wire logic [31:0]       acc_addr_i,
    input  wire logic [31:0]       acc_data_i,
    input  wire logic              acc_first_part_i,
    input  wire logic [31:0]       next_inst_addr_i,
    input  wire logic              debug_int_enable_i,
    output logic                   debug_event_o,
    output logic                   cancel_second_o,
    output logic      [3:0]        debug_status_o
);

    // -----------------------------------------------------------------
    // Parameter check
    // -----------------------------------------------------------------
    generate
        if (ADDR_W < 5) begin : g_bad_width
            $error("dvcd_top: ADDR_W must be at least 5");
        end
    endgenerate

    // -----------------------------------------------------------------
    // Registers and decode
    // -----------------------------------------------------------------
    logic [31:0] debug_control_1;
    logic [3:0]  debug_status;
    logic [31:0] addr_compare_1;
    logic [31:0] addr_compare_2;
    logic [31:0] data_value_compare_1;
    logic [31:0] data_value_compare_2;
    logic [31:0] save_restore_2;

    logic        bus_req;
    logic        bus_wr;
    logic [4:0]  bus_ofs;
    logic        in_map;
    logic [3:0]  status_set;
    logic [3:0]  status_clr;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i && in_map;
    assign bus_ofs = {wb_adr_i[4:2], 2'b00};
    assign in_map  = (wb_adr_i[ADDR_W-1:2] <= (ADDR_W-2)'(dvcd_pkg::OFS_SAVE_RESTORE_2 >> 2));

    // Merge write data into a word under the byte selects
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Control fields
    // -----------------------------------------------------------------
    logic       rd_check_1;
    logic       wr_check_1;
    logic       rd_check_2;
    logic       wr_check_2;
    logic       range_pair_enable;
    logic       range_exclusive_select;
    logic [1:0] match_size_1;
    logic [1:0] match_size_2;
    logic [3:0] value_byte_enable_1;
    logic [3:0] value_byte_enable_2;
    logic [1:0] value_compare_mode_1;
    logic [1:0] value_compare_mode_2;

    assign rd_check_1             = debug_control_1[dvcd_pkg::POS_RD_CHECK_1];
    assign wr_check_1             = debug_control_1[dvcd_pkg::POS_WR_CHECK_1];
    assign rd_check_2             = debug_control_1[dvcd_pkg::POS_RD_CHECK_2];
    assign wr_check_2             = debug_control_1[dvcd_pkg::POS_WR_CHECK_2];
    assign range_pair_enable      = debug_control_1[dvcd_pkg::POS_RANGE_PAIR];
    assign range_exclusive_select = debug_control_1[dvcd_pkg::POS_RANGE_EXCL];
    assign match_size_1           = debug_control_1[dvcd_pkg::POS_MATCH_SIZE_1 +: 2];
    assign match_size_2           = debug_control_1[dvcd_pkg::POS_MATCH_SIZE_2 +: 2];
    assign value_byte_enable_1    = debug_control_1[dvcd_pkg::POS_VALUE_BE_1 +: 4];
    assign value_byte_enable_2    = debug_control_1[dvcd_pkg::POS_VALUE_BE_2 +: 4];
    assign value_compare_mode_1   = debug_control_1[dvcd_pkg::POS_VALUE_MODE_1 +: 2];
    assign value_compare_mode_2   = debug_control_1[dvcd_pkg::POS_VALUE_MODE_2 +: 2];

    // -----------------------------------------------------------------
    // Access classification
    // -----------------------------------------------------------------
    logic is_read;
    logic is_write;

    // Untouched codes count as neither, so they raise nothing
    always_comb begin
        is_read  = 1'b0;
        is_write = 1'b0;
        case (acc_op_i)
            dvcd_pkg::OP_LOAD:            is_read  = 1'b1;
            dvcd_pkg::OP_STORE:           is_write = 1'b1;
            dvcd_pkg::OP_DBLK_INVALIDATE: is_write = 1'b1;
            dvcd_pkg::OP_DBLK_ZERO:       is_write = 1'b1;
            dvcd_pkg::OP_IBLK_INVALIDATE: is_read  = 1'b1;
            dvcd_pkg::OP_DBLK_FLUSH:      is_write = 1'b1;
            dvcd_pkg::OP_DBLK_STORE:      is_write = 1'b1;
            dvcd_pkg::OP_DTOUCH:          is_read  = 1'b1;
            dvcd_pkg::OP_DTOUCH_STORE:    is_read  = 1'b1;
            dvcd_pkg::OP_ITOUCH:          is_read  = 1'b1;
            dvcd_pkg::OP_DBLK_ALLOCATE:   is_write = 1'b1;
            default: begin
                // Class invalidates and cache reads carry no address
                is_read  = 1'b0;
                is_write = 1'b0;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Address compare
    // -----------------------------------------------------------------
    function automatic logic [31:0] size_mask(input logic [1:0] size);
        unique case (size)
            dvcd_pkg::SIZE_BYTE: return 32'hFFFF_FFFF;
            dvcd_pkg::SIZE_HALF: return 32'hFFFF_FFFE;
            dvcd_pkg::SIZE_WORD: return 32'hFFFF_FFFC;
            dvcd_pkg::SIZE_LINE: return 32'hFFFF_FFE0;
        endcase
    endfunction

    logic exact_hit_1;
    logic exact_hit_2;
    logic in_range;
    logic addr_hit_1;
    logic addr_hit_2;

    // Masked bits are the low-order ones of the big-endian address
    assign exact_hit_1 = ((acc_addr_i ^ addr_compare_1) & size_mask(match_size_1)) == 32'h0;
    assign exact_hit_2 = ((acc_addr_i ^ addr_compare_2) & size_mask(match_size_2)) == 32'h0;
    assign in_range    = ((acc_addr_i >= addr_compare_1) && (acc_addr_i < addr_compare_2))
                         ^ range_exclusive_select;

    // Range pair overrides exact compare; either check bit covers the range
    assign addr_hit_1 = range_pair_enable ? in_range : exact_hit_1;
    assign addr_hit_2 = range_pair_enable ? in_range : exact_hit_2;

    // -----------------------------------------------------------------
    // Value compare
    // -----------------------------------------------------------------
    logic value_en_1;
    logic value_en_2;
    logic value_match_1;
    logic value_match_2;

    assign value_en_1 = (value_byte_enable_1 != 4'h0);
    assign value_en_2 = (value_byte_enable_2 != 4'h0);

    dvcd_value_unit u_value_1 (
        .byte_enable_i (value_byte_enable_1),
        .mode_i        (value_compare_mode_1),
        .reference_i   (data_value_compare_1),
        .operand_i     (acc_data_i),
        .match_o       (value_match_1)
    );

    dvcd_value_unit u_value_2 (
        .byte_enable_i (value_byte_enable_2),
        .mode_i        (value_compare_mode_2),
        .reference_i   (data_value_compare_2),
        .operand_i     (acc_data_i),
        .match_o       (value_match_2)
    );

    // A channel qualifies on the value only when its compare is enabled
    logic qual_1;
    logic qual_2;

    assign qual_1 = addr_hit_1 && (!value_en_1 || value_match_1);
    assign qual_2 = addr_hit_2 && (!value_en_2 || value_match_2);

    // Separate read and write status per channel
    assign status_set[dvcd_pkg::POS_READ_HIT_1]  = acc_valid_i && is_read  && rd_check_1 && qual_1;
    assign status_set[dvcd_pkg::POS_WRITE_HIT_1] = acc_valid_i && is_write && wr_check_1 && qual_1;
    assign status_set[dvcd_pkg::POS_READ_HIT_2]  = acc_valid_i && is_read  && rd_check_2 && qual_2;
    assign status_set[dvcd_pkg::POS_WRITE_HIT_2] = acc_valid_i && is_write && wr_check_2 && qual_2;

    assign status_clr = (bus_wr && bus_ofs == dvcd_pkg::OFS_DEBUG_STATUS) ?
                        (wb_dat_i[3:0] & {4{wb_sel_i[0]}}) : 4'h0;

    // -----------------------------------------------------------------
    // Register writes
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_control_1      <= dvcd_pkg::RST_CONTROL;
            addr_compare_1       <= dvcd_pkg::RST_WORD;
            addr_compare_2       <= dvcd_pkg::RST_WORD;
            data_value_compare_1 <= dvcd_pkg::RST_WORD;
            data_value_compare_2 <= dvcd_pkg::RST_WORD;
        end else if (bus_wr) begin
            unique case (bus_ofs)
                dvcd_pkg::OFS_DEBUG_CONTROL_1: begin
                    debug_control_1 <= merge(debug_control_1, wb_dat_i, wb_sel_i)
                                       & {{(32-dvcd_pkg::CONTROL_BITS){1'b0}},
                                          {dvcd_pkg::CONTROL_BITS{1'b1}}};
                end
                dvcd_pkg::OFS_ADDR_COMPARE_1:   addr_compare_1 <= merge(addr_compare_1, wb_dat_i, wb_sel_i);
                dvcd_pkg::OFS_ADDR_COMPARE_2:   addr_compare_2 <= merge(addr_compare_2, wb_dat_i, wb_sel_i);
                dvcd_pkg::OFS_DATA_VALUE_CMP_1: data_value_compare_1 <= merge(data_value_compare_1, wb_dat_i, wb_sel_i);
                dvcd_pkg::OFS_DATA_VALUE_CMP_2: data_value_compare_2 <= merge(data_value_compare_2, wb_dat_i, wb_sel_i);
                default: begin
                    // Status, read-only and unmapped words ignore data here
                end
            endcase
        end
    end

    // Status is write-one-to-clear; a new hit wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_status <= dvcd_pkg::RST_STATUS;
        end else begin
            debug_status <= (debug_status & ~status_clr) | status_set;
        end
    end

    assign debug_status_o = debug_status;

    // -----------------------------------------------------------------
    // Event reporting
    // -----------------------------------------------------------------
    logic any_set;

    assign any_set = (status_set != 4'h0);

    // Reported the cycle after the completed access, so it follows the access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_event_o   <= 1'b0;
            cancel_second_o <= 1'b0;
            save_restore_2  <= dvcd_pkg::RST_WORD;
        end else begin
            debug_event_o   <= any_set;
            // A taken interrupt on the first half drops the second access
            cancel_second_o <= any_set && debug_int_enable_i && acc_first_part_i;
            if (any_set && debug_int_enable_i) begin
                save_restore_2 <= next_inst_addr_i;
            end
        end
    end

    // -----------------------------------------------------------------
    // Wishbone answer: one wait state, ack drops the cycle after
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i && in_map) begin
                unique case (bus_ofs)
                    dvcd_pkg::OFS_DEBUG_CONTROL_1:  wb_dat_o <= debug_control_1;
                    dvcd_pkg::OFS_DEBUG_STATUS:     wb_dat_o <= {28'h0, debug_status};
                    dvcd_pkg::OFS_ADDR_COMPARE_1:   wb_dat_o <= addr_compare_1;
                    dvcd_pkg::OFS_ADDR_COMPARE_2:   wb_dat_o <= addr_compare_2;
                    dvcd_pkg::OFS_DATA_VALUE_CMP_1: wb_dat_o <= data_value_compare_1;
                    dvcd_pkg::OFS_DATA_VALUE_CMP_2: wb_dat_o <= data_value_compare_2;
                    dvcd_pkg::OFS_SAVE_RESTORE_2:   wb_dat_o <= save_restore_2;
                    default:                        wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic write_only_op;
    assign write_only_op = acc_op_i inside {dvcd_pkg::OP_DBLK_INVALIDATE,
        dvcd_pkg::OP_DBLK_ZERO, dvcd_pkg::OP_DBLK_FLUSH, dvcd_pkg::OP_DBLK_STORE,
        dvcd_pkg::OP_DBLK_ALLOCATE};

    store_class_a: assert property (acc_valid_i && write_only_op |->
        !status_set[dvcd_pkg::POS_READ_HIT_1] && !status_set[dvcd_pkg::POS_READ_HIT_2])
        else $error("store-class cache op raised a read hit");
    load_class_a: assert property (acc_valid_i && acc_op_i inside {dvcd_pkg::OP_IBLK_INVALIDATE,
        dvcd_pkg::OP_DTOUCH, dvcd_pkg::OP_DTOUCH_STORE, dvcd_pkg::OP_ITOUCH} |->
        !status_set[dvcd_pkg::POS_WRITE_HIT_1] && !status_set[dvcd_pkg::POS_WRITE_HIT_2])
        else $error("load-class cache op raised a write hit");
    no_address_op_a: assert property (acc_valid_i && acc_op_i inside {dvcd_pkg::OP_DCLASS_INVAL,
        dvcd_pkg::OP_ICLASS_INVAL, dvcd_pkg::OP_DCACHE_READ, dvcd_pkg::OP_ICACHE_READ} |=>
        !debug_event_o) else $error("addressless cache op raised an event");
    value_fail_a: assert property (acc_valid_i && value_en_1 && addr_hit_1 && !value_match_1 |->
        !status_set[dvcd_pkg::POS_READ_HIT_1] && !status_set[dvcd_pkg::POS_WRITE_HIT_1])
        else $error("failed value compare set a status bit");
    and_mode_a: assert property (value_compare_mode_1 == dvcd_pkg::MODE_AND &&
        value_byte_enable_1 == 4'hF |-> value_match_1 == (acc_data_i == data_value_compare_1))
        else $error("AND mode mismatch on full word");
    hit_sticky_a: assert property (debug_status[0] && !status_clr[0] |=> debug_status[0])
        else $error("read hit status cleared by hardware");
    hit_record_a: assert property (status_set[dvcd_pkg::POS_WRITE_HIT_2] |=>
        debug_status[dvcd_pkg::POS_WRITE_HIT_2] && debug_event_o)
        else $error("write hit not recorded");
    return_addr_a: assert property (any_set && debug_int_enable_i |=>
        save_restore_2 == $past(next_inst_addr_i) ##1 $stable(save_restore_2) || $past(any_set))
        else $error("follow-on address not captured");
    split_cancel_a: assert property (any_set && debug_int_enable_i && acc_first_part_i |=>
        cancel_second_o && debug_event_o) else $error("second access not cancelled");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    value_hit_c: cover property (acc_valid_i && value_en_1 && value_match_1 && any_set);
    range_hit_c: cover property (acc_valid_i && range_pair_enable && any_set);
    and_or_hit_c: cover property (value_compare_mode_2 == dvcd_pkg::MODE_AND_OR &&
        status_set[dvcd_pkg::POS_READ_HIT_2]);

endmodule

// file: tb/dvcd_pipe_model.sv
// Stand-in for the load/store pipeline: one completed access per call.
// Assumes callers enter on a rising clock edge.
`timescale 1ns/10ps
module dvcd_pipe_model (
    input  wire logic        clk_i,
    output logic             acc_valid_o,
    output logic [3:0]       acc_op_o,
    output logic [31:0]      acc_addr_o,
    output logic [31:0]      acc_data_o,
    output logic             acc_first_part_o
);
    // Idle fields never match anything the bench programs
    initial begin
        acc_valid_o = 1'b0;
        acc_op_o = 4'hF;
        acc_addr_o = 32'hFFFF_FFFF;
        acc_data_o = 32'h0;
        acc_first_part_o = 1'b0;
    end
    // One-cycle strobe; fields flip after it so stale values cannot hit
    task issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] d,
               input logic fp);
        acc_valid_o <= 1'b1;
        acc_op_o <= op;
        acc_addr_o <= a;
        acc_data_o <= d;
        acc_first_part_o <= fp;
        @(posedge clk_i);
        acc_valid_o <= 1'b0;
        acc_op_o <= 4'hF;
        acc_addr_o <= ~a;
        acc_data_o <= ~d;
        acc_first_part_o <= ~fp;
    endtask
endmodule

// file: tb/tb_dvcd_top.sv
// Self-checking bench: Wishbone tasks, pipeline model, event checks.
// Assumes ack one cycle after the taking edge and status one edge after.
`timescale 1ns/10ps
module tb_dvcd_top;
    localparam logic [31:0] A = 32'h0000_2000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        ie = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wd = 32'h0;
    logic [31:0] nia = 32'h0000_1234;
    logic [31:0] rdat, rd;
    logic        ack, evt, cancel, av, afp;
    logic [3:0]  stat, aop;
    logic [31:0] aadr, adat;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc_n = 0;
    always #2.5 clk_i = ~clk_i;
    dvcd_pipe_model pm (.clk_i(clk_i), .acc_valid_o(av), .acc_op_o(aop), .acc_addr_o(aadr),
        .acc_data_o(adat), .acc_first_part_o(afp));
    dvcd_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .acc_valid_i(av), .acc_op_i(aop), .acc_addr_i(aadr), .acc_data_i(adat),
        .acc_first_part_i(afp), .next_inst_addr_i(nia), .debug_int_enable_i(ie),
        .debug_event_o(evt), .cancel_second_o(cancel), .debug_status_o(stat));
    task end_sim;
        $display("Compares %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard: far beyond the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            num_errors++;
            end_sim;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic cycle; read data taken at the ack edge, then one idle cycle
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        sel <= s;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    // One access; judges status, event pulse and cancel one edge later
    task acc(input logic [3:0] op, input logic [31:0] a, input logic [31:0] d,
             input logic fp, input logic [3:0] e);
        pm.issue(op, a, d, fp);
        #1;
        chk({cancel, evt, stat}, {fp & ie & (|e), |e, e});
        @(posedge clk_i);
        wb(1'b1, dvcd_pkg::OFS_DEBUG_STATUS, 32'hF, 4'h1);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, dvcd_pkg::OFS_DEBUG_CONTROL_1, 32'h0, 4'hF);
        chk(rd, dvcd_pkg::RST_CONTROL);
        wb(1'b0, 5'h1C, 32'h0, 4'hF);
        chk(rd, 32'h0);
        wb(1'b1, dvcd_pkg::OFS_ADDR_COMPARE_1, A, 4'hF);
        wb(1'b1, dvcd_pkg::OFS_DEBUG_CONTROL_1, 32'h3, 4'hF);
        // Every access kind against plain read and write checks
        for (int i = 0; i < 15; i++) begin
            acc(i[3:0], A, 32'h0, 1'b0, {2'b00, 30'h2568_01A9 >> (2 * i)} & 4'h3);
        end
        // Cacheline size on channel 1, then inclusive and exclusive range on channel 2
        wb(1'b1, dvcd_pkg::OFS_DEBUG_CONTROL_1, 32'h0000_00C2, 4'hF);
        acc(dvcd_pkg::OP_STORE, A + 32'h1F, 32'h0, 1'b0, 4'h2);
        acc(dvcd_pkg::OP_STORE, A + 32'h20, 32'h0, 1'b0, 4'h0);
        wb(1'b1, dvcd_pkg::OFS_ADDR_COMPARE_2, A + 32'h100, 4'hF);
        wb(1'b1, dvcd_pkg::OFS_DEBUG_CONTROL_1, 32'h0000_001C, 4'hF);
        acc(dvcd_pkg::OP_STORE, A + 32'h80, 32'h0, 1'b0, 4'h8);
        acc(dvcd_pkg::OP_LOAD, A + 32'h100, 32'h0, 1'b0, 4'h0);
        wb(1'b1, dvcd_pkg::OFS_DEBUG_CONTROL_1, 32'h0000_003C, 4'hF);
        acc(dvcd_pkg::OP_LOAD, A + 32'h100, 32'h0, 1'b0, 4'h4);
        wb(1'b1, dvcd_pkg::OFS_DATA_VALUE_CMP_1, 32'hABCD_0123, 4'hF);
        wb(1'b0, dvcd_pkg::OFS_DATA_VALUE_CMP_1, 32'h0, 4'hF);
        chk(rd, 32'hABCD_0123);
        wb(1'b1, dvcd_pkg::OFS_DEBUG_CONTROL_1, 32'hFFFF_FFFF, 4'hF);
        wb(1'b0, dvcd_pkg::OFS_DEBUG_CONTROL_1, 32'h0, 4'hF);
        chk(rd, 32'h003F_FFFF);
        // Byte enables 7, 8, C, F in each defined mode; mode 00 never set
        for (int i = 0; i < 4; i++) begin
            for (int m = 1; m < 4; m++) begin
                wb(1'b1, dvcd_pkg::OFS_DEBUG_CONTROL_1,
                   {12'h000, m[1:0], 4'h0, 4'(16'hFC87 >> (4 * i)), 10'h001}, 4'hF);
                acc(dvcd_pkg::OP_LOAD, A, 32'hABCD_FFFF, 1'b0, {3'b000, 12'hDDA >> (3 * i + m - 1)} & 4'h1);
            end
        end
        acc(dvcd_pkg::OP_LOAD, A + 32'h100, 32'hABCD_FFFF, 1'b0, 4'h0);
        ie <= 1'b1;
        @(posedge clk_i);
        acc(dvcd_pkg::OP_LOAD, A, 32'hABCD_FFFF, 1'b1, 4'h1);
        wb(1'b0, dvcd_pkg::OFS_SAVE_RESTORE_2, 32'h0, 4'hF);
        chk(rd, 32'h0000_1234);
        end_sim;
    end
endmodule
